// file: hw/ast_uart.sv
// Purpose: async serial transceiver with APB register access
// Assumes: i_rxd and i_timer_tick synchronous to i_clock
// Notes:   one wait state on every APB access
//
// The APB register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - transmit one or two high stop bits per stop-length setting
// - parity bit only when enabled, odd or even, shared by both directions
// - valid buffer write clears empty flag; frame is start, data, parity, stops
// - when shifting begins set empty flag and pulse transmit interrupt
// - line stays high while disabled and until the first byte is written; a frame in flight at disable still finishes
// - buffer write without prior status read is ignored, flag stays set
// - after stop bits load data only, set full flag, pulse receive interrupt
// - new character while buffer full sets overrun, character discarded
// - no reception while the overrun flag is set
// - receive disable takes effect only after the character in progress
// - parity fault flag set when received parity disagrees
// - framing fault flag set when a stop bit samples low
// - error and full flags clear on buffer read after status read
// - overrun set after the status read survives the buffer read
// - complete flag set when done and buffer empty; cleared at next start
// - both directions use the selected baud divider
// - sample each bit at ticks 7, 8, 9 of 16, majority decides
// - divider codes give 13..416, timer tick, or 96
module ast_uart
  import ast_pkg::*;
(
  input  wire logic         i_clock,
  input  wire logic         i_arst_n,
  input  wire ast_apb_req_t i_apb,
  output var  ast_apb_rsp_t o_apb,
  input  wire logic         i_rxd,
  input  wire logic         i_timer_tick,
  output var  logic         o_txd,
  output var  logic         o_transmit_interrupt,
  output var  logic         o_receive_interrupt
);

  // ==========================================================
  // state
  typedef struct packed {
    logic        transmit_enable;
    logic        receive_enable;
    logic        tx_stop_length;
    logic        rx_stop_length;
    logic        parity_even;
    logic        parity_enable;
    logic [2:0]  baud_divider_select;
    logic [8:0]  div_cnt;
    logic [7:0]  transmit_holding_buffer;
    logic        transmit_buffer_empty_flag;
    logic        transmit_complete_flag;
    logic        tx_armed;
    logic        rx_armed;
    logic        overrun_flag_seen;
    logic        tx_busy;
    logic [10:0] tx_sr;
    logic [3:0]  tx_bits;
    logic [3:0]  tx_tick;
    logic        txd;
    ast_rx_st_t  rx_st;
    logic [3:0]  receiver_sample_tick;
    logic [2:0]  rx_cnt;
    logic        s7;
    logic        s8;
    logic [7:0]  rx_sr;
    logic        rx_par;
    logic        rx_framing_fault_flag;
    logic [7:0]  receive_holding_buffer;
    logic        receive_full_flag;
    logic        parity_fault_flag;
    logic        framing_fault_flag;
    logic        overrun_flag;
    logic        txi;
    logic        rxi;
    ast_apb_rsp_t apb;
  } ast_state_t;

  ast_state_t st_q;
  ast_state_t st_d;
  logic       rst_meta_q;
  logic       rst_n_q;

  // ==========================================================
  // functions
  function automatic logic [8:0] baud_div(input logic [2:0] sel);
    case (sel)
      3'h0:    baud_div = AST_DIV_13;
      3'h1:    baud_div = AST_DIV_26;
      3'h2:    baud_div = AST_DIV_52;
      3'h3:    baud_div = AST_DIV_104;
      3'h4:    baud_div = AST_DIV_208;
      3'h5:    baud_div = AST_DIV_416;
      default: baud_div = AST_DIV_96;
    endcase
  endfunction : baud_div

  function automatic logic par_of(input logic [7:0] d, input logic even);
    par_of = even ? ^d : ~^d;
  endfunction : par_of

  // ==========================================================
  // reset release
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // ==========================================================
  // next state
  logic        acc;
  logic        done;
  logic        tick;
  logic        vote;
  logic        fin_ok;
  logic [31:0] rd_val;
  logic        mapped;
  logic [10:0] tail;

  always_comb begin
    st_d   = st_q;
    acc    = i_apb.psel & i_apb.penable;
    done   = acc & st_q.apb.pready;
    tick   = 1'b0;
    vote   = 1'b0;
    fin_ok = 1'b0;
    tail   = '0;
    st_d.txi = 1'b0;
    st_d.rxi = 1'b0;

    // register read value
    rd_val = '0;
    mapped = 1'b1;
    case (i_apb.paddr)
      AST_OFS_CTRL: begin
        rd_val[AST_CB_BRG_LO +: 3] = st_q.baud_divider_select;
        rd_val[AST_CB_PAR_EN]      = st_q.parity_enable;
        rd_val[AST_CB_EVEN]        = st_q.parity_even;
        rd_val[AST_CB_TSTOP2]      = st_q.tx_stop_length;
        rd_val[AST_CB_RXE]         = st_q.receive_enable;
        rd_val[AST_CB_TXE]         = st_q.transmit_enable;
        rd_val[AST_CB_RSTOP2]      = st_q.rx_stop_length;
      end
      AST_OFS_STATUS: begin
        rd_val[AST_SB_TRANSMIT_BUFFER_EMPTY_FLAG] = st_q.transmit_buffer_empty_flag;
        rd_val[AST_SB_TRANSMIT_COMPLETE_FLAG] = st_q.transmit_complete_flag;
        rd_val[AST_SB_RECEIVE_FULL_FLAG] = st_q.receive_full_flag;
        rd_val[AST_SB_OVERRUN_FLAG] = st_q.overrun_flag;
        rd_val[AST_SB_FRAMING_FAULT_FLAG] = st_q.framing_fault_flag;
        rd_val[AST_SB_PARITY_FAULT_FLAG] = st_q.parity_fault_flag;
      end
      AST_OFS_DATA: rd_val[7:0] = st_q.receive_holding_buffer;
      default:      mapped = 1'b0;
    endcase

    // registered answer costs one wait state but keeps outputs on flops
    st_d.apb.pready = acc & ~st_q.apb.pready;
    if (acc && !st_q.apb.pready) begin
      st_d.apb.prdata  = i_apb.pwrite ? 32'h0000_0000 : rd_val;
      st_d.apb.pslverr = ~mapped;
    end

    // ========================================================
    // register side effects, taken at the completing edge
    if (done && i_apb.pwrite) begin
      if (i_apb.paddr == AST_OFS_CTRL) begin
        st_d.baud_divider_select = i_apb.pwdata[AST_CB_BRG_LO +: 3];
        st_d.parity_enable       = i_apb.pwdata[AST_CB_PAR_EN];
        st_d.parity_even         = i_apb.pwdata[AST_CB_EVEN];
        st_d.tx_stop_length      = i_apb.pwdata[AST_CB_TSTOP2];
        st_d.receive_enable      = i_apb.pwdata[AST_CB_RXE];
        st_d.transmit_enable     = i_apb.pwdata[AST_CB_TXE];
        st_d.rx_stop_length      = i_apb.pwdata[AST_CB_RSTOP2];
      end
      if (i_apb.paddr == AST_OFS_DATA) begin
        st_d.tx_armed = 1'b0;
        if (st_q.tx_armed && st_q.transmit_buffer_empty_flag && st_q.transmit_enable) begin
          st_d.transmit_holding_buffer    = i_apb.pwdata[7:0];
          st_d.transmit_buffer_empty_flag = 1'b0;
        end
      end
    end
    if (done && !i_apb.pwrite) begin
      if (i_apb.paddr == AST_OFS_STATUS) begin
        st_d.tx_armed  = 1'b1;
        st_d.rx_armed  = 1'b1;
        st_d.overrun_flag_seen = st_q.overrun_flag;
      end
      if (i_apb.paddr == AST_OFS_DATA) begin
        st_d.rx_armed = 1'b0;
        if (st_q.rx_armed) begin
          st_d.receive_full_flag  = 1'b0;
          st_d.parity_fault_flag  = 1'b0;
          st_d.framing_fault_flag = 1'b0;
          if (st_q.overrun_flag_seen) begin
            st_d.overrun_flag = 1'b0;
          end
        end
      end
    end

    // ========================================================
    // baud tick, sixteen per bit
    if (st_q.baud_divider_select == AST_BRG_TIMER) begin
      tick = i_timer_tick;
    end else if (st_q.div_cnt >= baud_div(st_q.baud_divider_select) - 9'h001) begin
      st_d.div_cnt = '0;
      tick         = 1'b1;
    end else begin
      st_d.div_cnt = st_q.div_cnt + 9'h001;
    end

    // ========================================================
    // transmitter; disable only blocks the next load, not a frame in flight
    if (st_q.tx_busy) begin
      if (tick) begin
        st_d.tx_tick = st_q.tx_tick + 4'h1;
        if (st_q.tx_tick == AST_RT_LAST) begin
          if (st_q.tx_bits == 4'h1) begin
            st_d.tx_busy = 1'b0;
            st_d.txd     = 1'b1;
            st_d.transmit_complete_flag = st_d.transmit_buffer_empty_flag;
          end else begin
            st_d.txd     = st_q.tx_sr[0];
            st_d.tx_sr   = {1'b1, st_q.tx_sr[10:1]};
            st_d.tx_bits = st_q.tx_bits - 4'h1;
          end
        end
      end
    end else if (!st_q.transmit_buffer_empty_flag && st_q.transmit_enable) begin
      if (st_q.parity_enable) begin
        tail = {2'b11, par_of(st_q.transmit_holding_buffer, st_q.parity_even),
                st_q.transmit_holding_buffer};
      end else begin
        tail = {3'b111, st_q.transmit_holding_buffer};
      end
      st_d.tx_sr   = tail;
      st_d.txd     = 1'b0;
      st_d.tx_busy = 1'b1;
      st_d.tx_tick = '0;
      st_d.tx_bits = AST_TX_BASE + {3'h0, st_q.parity_enable}
                     + {3'h0, st_q.tx_stop_length};
      st_d.transmit_buffer_empty_flag = 1'b1;
      st_d.txi = 1'b1;
      st_d.transmit_complete_flag = 1'b0;
    end

    // ========================================================
    // receiver
    if (tick) begin
      case (st_q.rx_st)
        AST_RX_IDLE: begin
          // enable sampled only here, so clearing it lets a frame finish
          if (st_q.receive_enable && !st_q.overrun_flag && !i_rxd) begin
            st_d.rx_st = AST_RX_START;
            st_d.receiver_sample_tick = AST_RT_FIRST;
            st_d.rx_framing_fault_flag = 1'b0;
          end
        end
        default: begin
          st_d.receiver_sample_tick = st_q.receiver_sample_tick + 4'h1;
          if (st_q.receiver_sample_tick == AST_RT_S7) begin
            st_d.s7 = i_rxd;
          end
          if (st_q.receiver_sample_tick == AST_RT_S8) begin
            st_d.s8 = i_rxd;
          end
          if (st_q.receiver_sample_tick == AST_RT_VOTE) begin
            vote = (st_q.s7 & st_q.s8) | (st_q.s7 & i_rxd) | (st_q.s8 & i_rxd);
            case (st_q.rx_st)
              AST_RX_START: begin
                st_d.rx_st  = vote ? AST_RX_IDLE : AST_RX_DATA;
                st_d.rx_cnt = '0;
              end
              AST_RX_DATA: begin
                st_d.rx_sr = {vote, st_q.rx_sr[7:1]};
                st_d.rx_cnt = st_q.rx_cnt + 3'h1;
                if (st_q.rx_cnt == AST_DATA_LAST) begin
                  st_d.rx_st  = st_q.parity_enable ? AST_RX_PAR : AST_RX_STOP;
                  st_d.rx_cnt = '0;
                end
              end
              AST_RX_PAR: begin
                st_d.rx_par = vote;
                st_d.rx_st  = AST_RX_STOP;
              end
              AST_RX_STOP: begin
                st_d.rx_framing_fault_flag = st_q.rx_framing_fault_flag | ~vote;
                if (st_q.rx_stop_length && st_q.rx_cnt == 3'h0) begin
                  st_d.rx_cnt = 3'h1;
                end else begin
                  st_d.rx_st = AST_RX_IDLE;
                  fin_ok     = 1'b1;
                end
              end
              default: st_d.rx_st = AST_RX_IDLE;
            endcase
          end
        end
      endcase
    end

    // hardware sets come last so they win over a same-cycle clear
    if (fin_ok) begin
      if (st_q.receive_full_flag) begin
        st_d.overrun_flag = 1'b1;
      end else begin
        st_d.receive_holding_buffer = st_d.rx_sr;
        st_d.receive_full_flag      = 1'b1;
        st_d.rxi                    = 1'b1;
        st_d.framing_fault_flag     = st_d.rx_framing_fault_flag;
        st_d.parity_fault_flag      = st_q.parity_enable
                                      & (st_q.rx_par != par_of(st_q.rx_sr, st_q.parity_even));
      end
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge i_clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      st_q      <= '0;
      st_q.txd  <= 1'b1;
      st_q.transmit_buffer_empty_flag <= 1'b1;
      st_q.transmit_complete_flag     <= 1'b1;
      st_q.rx_st <= AST_RX_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_apb                = st_q.apb;
  assign o_txd                = st_q.txd;
  assign o_transmit_interrupt = st_q.txi;
  assign o_receive_interrupt  = st_q.rxi;

endmodule : ast_uart

`default_nettype wire

// file: hw/ast_pkg.sv
// Purpose: shared constants and types for the async serial transceiver
// Assumes: 32-bit APB register access, one system clock
// Notes:   register offsets are byte addresses
package ast_pkg;

  // ==========================================================
  // register map
  localparam logic [7:0] AST_OFS_CTRL   = 8'h00;
  localparam logic [7:0] AST_OFS_STATUS = 8'h04;
  localparam logic [7:0] AST_OFS_DATA   = 8'h08;

  // ==========================================================
  // control field positions
  localparam int AST_CB_BRG_LO  = 0;
  localparam int AST_CB_PAR_EN  = 3;
  localparam int AST_CB_EVEN    = 4;
  localparam int AST_CB_TSTOP2  = 5;
  localparam int AST_CB_RXE     = 6;
  localparam int AST_CB_TXE     = 7;
  localparam int AST_CB_RSTOP2  = 8;

  // status field positions
  localparam int AST_SB_TRANSMIT_BUFFER_EMPTY_FLAG    = 2;
  localparam int AST_SB_TRANSMIT_COMPLETE_FLAG    = 3;
  localparam int AST_SB_RECEIVE_FULL_FLAG    = 4;
  localparam int AST_SB_OVERRUN_FLAG    = 5;
  localparam int AST_SB_FRAMING_FAULT_FLAG    = 6;
  localparam int AST_SB_PARITY_FAULT_FLAG    = 7;

  // ==========================================================
  // baud divider codes and divisors
  localparam logic [2:0] AST_BRG_TIMER = 3'h6;
  localparam logic [8:0] AST_DIV_13    = 9'h00D;
  localparam logic [8:0] AST_DIV_26    = 9'h01A;
  localparam logic [8:0] AST_DIV_52    = 9'h034;
  localparam logic [8:0] AST_DIV_104   = 9'h068;
  localparam logic [8:0] AST_DIV_208   = 9'h0D0;
  localparam logic [8:0] AST_DIV_416   = 9'h1A0;
  localparam logic [8:0] AST_DIV_96    = 9'h060;

  // ==========================================================
  // receiver sample ticks, frame sizes
  localparam logic [3:0] AST_RT_S7     = 4'h7;
  localparam logic [3:0] AST_RT_S8     = 4'h8;
  localparam logic [3:0] AST_RT_VOTE   = 4'h9;
  localparam logic [3:0] AST_RT_LAST   = 4'hF;
  localparam logic [3:0] AST_RT_FIRST  = 4'h1;
  localparam logic [2:0] AST_DATA_LAST = 3'h7;
  localparam logic [3:0] AST_TX_BASE   = 4'hA;

  typedef enum logic [2:0] {
    AST_RX_IDLE, AST_RX_START, AST_RX_DATA, AST_RX_PAR, AST_RX_STOP
  } ast_rx_st_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } ast_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } ast_apb_rsp_t;

endpackage : ast_pkg

// file: verif/ast_uart_props.sv
// Purpose: port-level checks for the async serial transceiver
// Assumes: APB master keeps an idle cycle between transfers
// Notes:   bound into ast_uart, sees its ports only
`timescale 1ns/1ps
`default_nettype none
module ast_uart_props
  import ast_pkg::*;
(
  input wire logic         i_clock,
  input wire logic         i_arst_n,
  input wire ast_apb_req_t i_apb,
  input wire ast_apb_rsp_t o_apb,
  input wire logic         i_rxd,
  input wire logic         i_timer_tick,
  input wire logic         o_txd,
  input wire logic         o_transmit_interrupt,
  input wire logic         o_receive_interrupt
);
  // ==========================================================
  // helpers
  logic        started_q;
  logic        wrote_q;
  logic [16:0] low_age_q;
  logic        dwr;
  logic        done;
  assign done = i_apb.psel && i_apb.penable && o_apb.pready;
  assign dwr  = done && i_apb.pwrite && i_apb.paddr == AST_OFS_DATA;
  // age saturates: slowest frame is far below the top value
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      started_q <= 1'b0;
      wrote_q   <= 1'b0;
      low_age_q <= '1;
    end else begin
      started_q <= started_q | o_transmit_interrupt;
      wrote_q   <= dwr | (wrote_q & !o_transmit_interrupt);
      low_age_q <= !i_rxd ? 17'h0 : low_age_q + 17'(low_age_q != '1);
    end
  end
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_arst_n);
  // ==========================================================
  // assertions
  a_idle_high: assert property (!started_q && !o_transmit_interrupt |-> o_txd)
    else $error("line left idle before first start");
  a_start_low: assert property (o_transmit_interrupt |-> !o_txd [*8])
    else $error("start bit not low");
  a_tx_cause: assert property (o_transmit_interrupt |-> wrote_q)
    else $error("transmit began without a data write");
  a_tx_pulse: assert property (o_transmit_interrupt |=> !o_transmit_interrupt)
    else $error("transmit interrupt longer than one cycle");
  a_rx_pulse: assert property (o_receive_interrupt |=> !o_receive_interrupt)
    else $error("receive interrupt longer than one cycle");
  a_rx_cause: assert property (o_receive_interrupt |-> low_age_q < 17'd80000)
    else $error("receive without a start bit");
  a_one_wait: assert property (i_apb.psel && !i_apb.penable |=> !o_apb.pready ##1 o_apb.pready)
    else $error("ready not after one wait state");
  a_ready_once: assert property (o_apb.pready |=> !o_apb.pready)
    else $error("ready held too long");
  a_bad_addr: assert property (done && i_apb.paddr > AST_OFS_DATA
                               |-> o_apb.pslverr && o_apb.prdata == 32'h0)
    else $error("unmapped access not refused");
  c_tx: cover property (o_transmit_interrupt);
  c_rx: cover property (o_receive_interrupt);
  c_err: cover property (o_apb.pslverr);
endmodule : ast_uart_props
bind ast_uart ast_uart_props ast_uart_props_inst (.i_clock, .i_arst_n, .i_apb, .o_apb,
  .i_rxd, .i_timer_tick, .o_txd, .o_transmit_interrupt, .o_receive_interrupt);
`default_nettype wire

// file: verif/ast_peer.sv
// Purpose: remote serial peer on the transmit and receive lines
// Assumes: bit time counted in system clocks
// Notes:   captured frames are queued for the bench
`timescale 1ns/1ps
`default_nettype none
module ast_peer (
  input  wire logic i_clock,
  input  wire logic i_txd,
  output var  logic o_rxd
);
  int          per;
  int          nb;
  logic [11:0] cur;
  logic [11:0] got [$];
  initial begin
    per   = 208;
    nb    = 10;
    o_rxd = 1'b1;
  end
  // ==========================================================
  // sender, bit 0 first, line back high after the frame
  task automatic send(input logic [11:0] f, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge i_clock);
      o_rxd <= f[i];
      repeat (per - 1) @(posedge i_clock);
    end
    @(posedge i_clock);
    o_rxd <= 1'b1;
  endtask : send
  // ==========================================================
  // receiver, mid-bit sampling; rearms right after sampling the last bit, half a bit before its end
  always begin
    @(negedge i_txd);
    cur = '1;
    repeat (per / 2) @(posedge i_clock);
    for (int i = 0; i < nb; i++) begin
      cur[i] = i_txd;
      if (i < nb - 1) repeat (per) @(posedge i_clock);
    end
    got.push_back(cur);
  end
endmodule : ast_peer
`default_nettype wire

// file: verif/testbench.sv
// Purpose: register and line tests for the async serial transceiver
// Assumes: one wait state APB, 13-clock tick on select 0
// Notes:   timer tick input pulses every 13 clocks
`timescale 1ns/1ps
`default_nettype none
module testbench
  import ast_pkg::*;
;
  logic         i_clock;
  logic         i_arst_n;
  logic         tick;
  int           tick_cnt;
  ast_apb_req_t req;
  ast_apb_rsp_t rsp;
  logic         rxd;
  logic         txd;
  logic         tx_int;
  logic         rx_int;
  logic [31:0]  rd;
  logic         err_bit;
  int           err_total;
  int           tests_run;
  logic [7:0]   cfg   [4] = '{8'hA8, 8'h99, 8'h86, 8'h80};
  int           per_t [4] = '{208, 416, 208, 208};
  ast_uart ast_uart_inst (.i_clock, .i_arst_n, .i_apb(req), .o_apb(rsp), .i_rxd(rxd),
    .i_timer_tick(tick), .o_txd(txd), .o_transmit_interrupt(tx_int),
    .o_receive_interrupt(rx_int));
  ast_peer ast_peer_inst (.i_clock, .i_txd(txd), .o_rxd(rxd));
  always #2 i_clock = ~i_clock;
  always @(posedge i_clock) begin
    tick_cnt <= (tick_cnt == 12) ? 0 : tick_cnt + 1;
    tick     <= (tick_cnt == 12);
  end
  // ==========================================================
  // tasks
  task automatic finish_test;
    $display("checks %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clock);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge i_clock);
    req.penable <= 1'b1;
    do @(posedge i_clock); while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err_bit = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rdc
  function automatic logic [11:0] frame(input logic [7:0] d, input logic pe, input logic ev);
    logic [11:0] f;
    f = 12'hFFF;
    f[0] = 1'b0;
    f[8:1] = d;
    if (pe) f[9] = ^d ^ ~ev;
    return f;
  endfunction : frame
  // one idle bit first so a false start can settle
  task automatic rxs(input logic [7:0] d, input logic [11:0] flip);
    repeat (208) @(posedge i_clock);
    ast_peer_inst.send(frame(d, 1'b1, 1'b0) ^ flip, 11);
  endtask : rxs
  initial begin
    #400000;
    err_total++;
    finish_test();
  end
  // ==========================================================
  // main sequence
  initial begin
    i_clock = 1'b0;
    i_arst_n = 1'b0;
    tick = 1'b0;
    tick_cnt = 0;
    req = '0;
    err_total = 0;
    tests_run = 0;
    repeat (2) @(posedge i_clock);
    i_arst_n <= 1'b1;
    repeat (3) @(posedge i_clock);
    wr(AST_OFS_CTRL, 32'h80);
    wr(AST_OFS_DATA, 32'h5A);
    rdc(AST_OFS_STATUS, 32'h0C);
    repeat (500) @(posedge i_clock);
    chk({31'h0, txd} | 32'(ast_peer_inst.got.size() << 1), 32'h1);
    for (int k = 0; k < 4; k++) begin
      ast_peer_inst.per = per_t[k];
      ast_peer_inst.nb = 10 + cfg[k][3] + cfg[k][5];
      wr(AST_OFS_CTRL, 32'h0);
      wr(AST_OFS_CTRL, {24'h0, cfg[k]});
      rdc(AST_OFS_STATUS, 32'h0C);
      wr(AST_OFS_DATA, {24'h0, 8'hC3 ^ 8'(k)});
      rdc(AST_OFS_STATUS, 32'h04);
      wr(AST_OFS_DATA, {24'h0, 8'h35 + 8'(k)});
      for (int t = 0; t < 40000 && ast_peer_inst.got.size() < 2 * k + 2; t++)
        @(posedge i_clock);
      repeat (ast_peer_inst.per) @(posedge i_clock);
      rdc(AST_OFS_STATUS, 32'h0C);
      chk({20'h0, ast_peer_inst.got[2*k]}, {20'h0, frame(8'hC3 ^ 8'(k), cfg[k][3], cfg[k][4])});
      chk({20'h0, ast_peer_inst.got[2*k+1]}, {20'h0, frame(8'h35 + 8'(k), cfg[k][3], cfg[k][4])});
    end
    wr(AST_OFS_CTRL, 32'h0);
    wr(AST_OFS_CTRL, 32'hC8);
    rxs(8'hA5, 12'h0);
    rdc(AST_OFS_STATUS, 32'h1C);
    rdc(AST_OFS_DATA, 32'hA5);
    rdc(AST_OFS_STATUS, 32'h0C);
    rxs(8'h3C, 12'h200);
    rdc(AST_OFS_STATUS, 32'h9C);
    rdc(AST_OFS_DATA, 32'h3C);
    rdc(AST_OFS_STATUS, 32'h0C);
    rxs(8'h7E, 12'h400);
    rdc(AST_OFS_STATUS, 32'h5C);
    rdc(AST_OFS_DATA, 32'h7E);
    rdc(AST_OFS_STATUS, 32'h0C);
    rxs(8'h11, 12'h0);
    rxs(8'h22, 12'h0);
    rxs(8'h33, 12'h0);
    rdc(AST_OFS_STATUS, 32'h3C);
    rdc(AST_OFS_DATA, 32'h11);
    rdc(AST_OFS_STATUS, 32'h0C);
    rxs(8'h44, 12'h0);
    rdc(AST_OFS_STATUS, 32'h1C);
    rxs(8'h55, 12'h0);
    rdc(AST_OFS_DATA, 32'h44);
    rdc(AST_OFS_STATUS, 32'h2C);
    rdc(AST_OFS_DATA, 32'h44);
    rdc(AST_OFS_STATUS, 32'h0C);
    fork
      rxs(8'h77, 12'h0);
      begin
        repeat (900) @(posedge i_clock);
        wr(AST_OFS_CTRL, 32'h88);
      end
    join
    rdc(AST_OFS_STATUS, 32'h1C);
    rdc(AST_OFS_DATA, 32'h77);
    rxs(8'h66, 12'h0);
    rdc(AST_OFS_STATUS, 32'h0C);
    wr(8'h10, 32'hFF);
    rdc(AST_OFS_CTRL, 32'h88);
    rdc(8'h0C, 32'h0);
    chk({31'h0, err_bit}, 32'h1);
    finish_test();
  end
endmodule : testbench
`default_nettype wire
